// >>> logic/spp_pkg.sv
// Purpose: shared constants and types for the scan pin sharing and probe block
// Assumes: one system clock domain; all pins sampled by that clock
// Notes: pin vector index map is shared by the top and the bench
package spp_pkg;

   // index of each shared pin in the pin vectors
   localparam int PIN_TCK = 0;
   localparam int PIN_TDI = 1;
   localparam int PIN_TDO = 2;
   localparam int PIN_PROBE_A = 3;
   localparam int PIN_PROBE_B = 4;
   localparam int NUM_PINS = 5;
   // the mode select pin sits above the shared pins in the sync vector
   localparam int SYNC_TMS = 5;
   localparam int SYNC_W = 6;

   // instruction register
   localparam int IR_W = 4;
   localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
   localparam logic [3:0] IR_PROBE_SEL = 4'h2;
   localparam logic [3:0] IR_PROGRAM = 4'h3;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_RESET_VAL = 4'hF;

   // tck cycles with mode select high that always reach the reset state
   localparam int TAP_RESET_TCK_CYCLES = 5;

   // boundary scan controller states
   typedef enum logic [3:0] {
      SPP_RESET      = 4'h0,
      SPP_IDLE       = 4'h1,
      SPP_SEL_DR     = 4'h2,
      SPP_CAP_DR     = 4'h3,
      SPP_SHIFT_DR   = 4'h4,
      SPP_EXIT1_DR   = 4'h5,
      SPP_PAUSE_DR   = 4'h6,
      SPP_EXIT2_DR   = 4'h7,
      SPP_UPDATE_DR  = 4'h8,
      SPP_SEL_IR     = 4'h9,
      SPP_CAP_IR     = 4'hA,
      SPP_SHIFT_IR   = 4'hB,
      SPP_EXIT1_IR   = 4'hC,
      SPP_PAUSE_IR   = 4'hD,
      SPP_EXIT2_IR   = 4'hE,
      SPP_UPDATE_IR  = 4'hF
   } spp_tap_state_t;

endpackage

// >>> logic/spp_tap_if.sv
// Purpose: carries sampled scan pin events between the pin top and the scan controller
// Assumes: all signals on clk_sys_in
// Notes: tck_rise is a one-cycle pulse per accepted test clock rising edge
`timescale 1ns/1ps
interface spp_tap_if;
   logic tck_rise;
   logic tms;
   logic tdi;
   spp_pkg::spp_tap_state_t state;
   logic [spp_pkg::IR_W-1:0] ir;
   logic ir_lsb;

   modport ctrl (
      output tck_rise,
      output tms,
      output tdi,
      input state,
      input ir,
      input ir_lsb
   );

   modport tap (
      input tck_rise,
      input tms,
      input tdi,
      output state,
      output ir,
      output ir_lsb
   );
endinterface

// >>> logic/spp_tap_ctrl.sv
// Purpose: boundary scan state machine and instruction register
// Assumes: test clock edges arrive as pulses already sampled by the system clock
// Notes: state advances only on accepted rising test clock edges
`timescale 1ns/1ps
module spp_tap_ctrl (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   spp_tap_if.tap tap
);

   spp_pkg::spp_tap_state_t state;
   spp_pkg::spp_tap_state_t next_state;
   logic [spp_pkg::IR_W-1:0] ir_shift;
   logic [spp_pkg::IR_W-1:0] ir;

   // standard sixteen state walk; five highs reach reset from anywhere
   function automatic spp_pkg::spp_tap_state_t step(input spp_pkg::spp_tap_state_t s, input logic m);
      case (s)
         spp_pkg::SPP_RESET: step = m ? spp_pkg::SPP_RESET : spp_pkg::SPP_IDLE;
         spp_pkg::SPP_IDLE: step = m ? spp_pkg::SPP_SEL_DR : spp_pkg::SPP_IDLE;
         spp_pkg::SPP_SEL_DR: step = m ? spp_pkg::SPP_SEL_IR : spp_pkg::SPP_CAP_DR;
         spp_pkg::SPP_CAP_DR: step = m ? spp_pkg::SPP_EXIT1_DR : spp_pkg::SPP_SHIFT_DR;
         spp_pkg::SPP_SHIFT_DR: step = m ? spp_pkg::SPP_EXIT1_DR : spp_pkg::SPP_SHIFT_DR;
         spp_pkg::SPP_EXIT1_DR: step = m ? spp_pkg::SPP_UPDATE_DR : spp_pkg::SPP_PAUSE_DR;
         spp_pkg::SPP_PAUSE_DR: step = m ? spp_pkg::SPP_EXIT2_DR : spp_pkg::SPP_PAUSE_DR;
         spp_pkg::SPP_EXIT2_DR: step = m ? spp_pkg::SPP_UPDATE_DR : spp_pkg::SPP_SHIFT_DR;
         spp_pkg::SPP_UPDATE_DR: step = m ? spp_pkg::SPP_SEL_DR : spp_pkg::SPP_IDLE;
         spp_pkg::SPP_SEL_IR: step = m ? spp_pkg::SPP_RESET : spp_pkg::SPP_CAP_IR;
         spp_pkg::SPP_CAP_IR: step = m ? spp_pkg::SPP_EXIT1_IR : spp_pkg::SPP_SHIFT_IR;
         spp_pkg::SPP_SHIFT_IR: step = m ? spp_pkg::SPP_EXIT1_IR : spp_pkg::SPP_SHIFT_IR;
         spp_pkg::SPP_EXIT1_IR: step = m ? spp_pkg::SPP_UPDATE_IR : spp_pkg::SPP_PAUSE_IR;
         spp_pkg::SPP_PAUSE_IR: step = m ? spp_pkg::SPP_EXIT2_IR : spp_pkg::SPP_PAUSE_IR;
         spp_pkg::SPP_EXIT2_IR: step = m ? spp_pkg::SPP_UPDATE_IR : spp_pkg::SPP_SHIFT_IR;
         spp_pkg::SPP_UPDATE_IR: step = m ? spp_pkg::SPP_SEL_DR : spp_pkg::SPP_IDLE;
         default: step = spp_pkg::SPP_RESET;
      endcase
   endfunction

   always_comb begin
      next_state = step(state, tap.tms);
   end

   // state register, moved only by accepted test clock edges
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= spp_pkg::SPP_RESET;
      end else if (tap.tck_rise) begin
         state <= next_state;
      end
   end

   // instruction shift path and update; reset state restores bypass
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ir_shift <= spp_pkg::IR_RESET_VAL;
         ir <= spp_pkg::IR_RESET_VAL;
      end else if (tap.tck_rise) begin
         case (state)
            spp_pkg::SPP_RESET: begin
               ir <= spp_pkg::IR_RESET_VAL;
            end
            spp_pkg::SPP_CAP_IR: begin
               ir_shift <= spp_pkg::IR_CAPTURE_VAL;
            end
            spp_pkg::SPP_SHIFT_IR: begin
               ir_shift <= {tap.tdi, ir_shift[spp_pkg::IR_W-1:1]};
            end
            spp_pkg::SPP_UPDATE_IR: begin
               ir <= ir_shift;
            end
            default: begin
               ir <= ir;
            end
         endcase
      end
   end

   assign tap.state = state;
   assign tap.ir = ir;
   assign tap.ir_lsb = ir_shift[0];

endmodule

// >>> logic/spp_scan_pin_top.sv
// Purpose: shares test clock, data in and data out pins and two probe pins with user i/o
// Assumes: tester test clock far slower than clk_sys_in; mode and fuse inputs static
// Notes: every pin input passes two flops; pin outputs and enables are registered
`timescale 1ns/1ps
module spp_scan_pin_top #(
   parameter int NUM_NODES = 16
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic dedicated_mode_in,
   input wire logic probe_fuse_blown_in,
   input wire logic tms_in,
   input wire logic [spp_pkg::NUM_PINS-1:0] shared_pin_in,
   output logic [spp_pkg::NUM_PINS-1:0] shared_pin_out,
   output logic [spp_pkg::NUM_PINS-1:0] shared_pin_oe_n_out,
   input wire logic [spp_pkg::NUM_PINS-1:0] user_pin_data_in,
   input wire logic [spp_pkg::NUM_PINS-1:0] user_pin_oe_n_in,
   output logic [spp_pkg::NUM_PINS-1:0] user_pin_read_out,
   input wire logic [NUM_NODES-1:0] probe_node_in,
   output logic scan_active_out,
   output logic prog_bit_out,
   output logic prog_bit_valid_out
);

   localparam int SEL_W = (NUM_NODES > 1) ? $clog2(NUM_NODES) : 1;
   localparam int CFG_W = 2 * (SEL_W + 1);

   // refuse node counts the selector cannot address cleanly, at elaboration
   if (NUM_NODES < 2 || NUM_NODES > 1024) begin : g_bad_nodes
      $error("spp_scan_pin_top: NUM_NODES must lie in 2..1024");
   end

   spp_tap_if tap_bus ();

   logic [spp_pkg::SYNC_W-1:0] sync_a;
   logic [spp_pkg::SYNC_W-1:0] sync_b;
   logic tck_prev;
   logic tck_rise_raw;
   logic tck_fall_raw;
   logic tck_rise;
   logic tck_fall;
   logic scan_active;
   logic next_scan_active;
   logic [CFG_W-1:0] dr_shift;
   logic [CFG_W-1:0] probe_cfg;
   logic tdo_bit;
   logic tdo_drive;
   logic in_shift;
   logic in_shift_dr;
   logic in_shift_ir;
   logic probe_a_en;
   logic probe_b_en;
   logic [SEL_W-1:0] probe_a_sel;
   logic [SEL_W-1:0] probe_b_sel;
   logic probe_a_val;
   logic probe_b_val;
   logic [SEL_W:0] probe_a_field;
   logic [SEL_W:0] probe_b_field;

   // field layout of the probe setup word: {en_b, sel_b, en_a, sel_a}
   function automatic logic [SEL_W:0] cfg_field(input logic [CFG_W-1:0] cfg, input logic hi);
      cfg_field = hi ? cfg[CFG_W-1:SEL_W+1] : cfg[SEL_W:0];
   endfunction

   // node pick shared by both probe channels
   function automatic logic pick_node(input logic [NUM_NODES-1:0] nodes, input logic [SEL_W-1:0] sel);
      pick_node = (int'(sel) < NUM_NODES) ? nodes[sel] : 1'b0;
   endfunction

   // two-flop synchronisers; only the second stage is looked at
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         // mode select idles high; a low reset value would fake a scan claim
         sync_a <= {1'b1, {spp_pkg::NUM_PINS{1'b0}}};
         sync_b <= {1'b1, {spp_pkg::NUM_PINS{1'b0}}};
      end else begin
         sync_a <= {tms_in, shared_pin_in};
         sync_b <= sync_a;
      end
   end

   // edge finder on the sampled test clock
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tck_prev <= 1'b0;
      end else begin
         tck_prev <= sync_b[spp_pkg::PIN_TCK];
      end
   end

   assign tck_rise_raw = sync_b[spp_pkg::PIN_TCK] & ~tck_prev;
   assign tck_fall_raw = ~sync_b[spp_pkg::PIN_TCK] & tck_prev;
   // user toggling on the shared clock pin must not walk the controller
   assign tck_rise = tck_rise_raw & scan_active;
   assign tck_fall = tck_fall_raw & scan_active;

   assign tap_bus.tck_rise = tck_rise;
   assign tap_bus.tms = sync_b[spp_pkg::SYNC_TMS];
   assign tap_bus.tdi = sync_b[spp_pkg::PIN_TDI];

   spp_tap_ctrl u_tap (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .tap(tap_bus.tap)
   );

   // pin role: dedicated mode or low mode select claims the pins; otherwise the reset state gives them back
   always_comb begin
      if (dedicated_mode_in) begin
         next_scan_active = 1'b1;
      end else if (!sync_b[spp_pkg::SYNC_TMS]) begin
         next_scan_active = 1'b1;
      end else if (tap_bus.state == spp_pkg::SPP_RESET) begin
         next_scan_active = 1'b0;
      end else begin
         next_scan_active = scan_active;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scan_active <= 1'b0;
      end else begin
         scan_active <= next_scan_active;
      end
   end

   assign in_shift_dr = (tap_bus.state == spp_pkg::SPP_SHIFT_DR);
   assign in_shift_ir = (tap_bus.state == spp_pkg::SPP_SHIFT_IR);
   assign in_shift = in_shift_dr | in_shift_ir;

   // data register path, chosen by the current instruction
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dr_shift <= '0;
      end else if (tck_rise) begin
         if (tap_bus.state == spp_pkg::SPP_CAP_DR) begin
            dr_shift <= (tap_bus.ir == spp_pkg::IR_PROBE_SEL) ? probe_cfg : '0;
         end else if (in_shift_dr) begin
            if (tap_bus.ir == spp_pkg::IR_PROBE_SEL) begin
               dr_shift <= {tap_bus.tdi, dr_shift[CFG_W-1:1]};
            end else begin
               // bypass and programming both use a single stage
               dr_shift <= {{(CFG_W-1){1'b0}}, tap_bus.tdi};
            end
         end
      end
   end

   // probe setup survives the controller reset so probes keep running
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         probe_cfg <= '0;
      end else if (probe_fuse_blown_in) begin
         probe_cfg <= '0;
      end else if (tck_rise && tap_bus.state == spp_pkg::SPP_UPDATE_DR
                   && tap_bus.ir == spp_pkg::IR_PROBE_SEL) begin
         probe_cfg <= dr_shift;
      end
   end

   // programming stream: one bit per test clock while shifting
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prog_bit_out <= 1'b0;
         prog_bit_valid_out <= 1'b0;
      end else begin
         prog_bit_valid_out <= tck_rise & in_shift_dr & (tap_bus.ir == spp_pkg::IR_PROGRAM);
         if (tck_rise && in_shift_dr && tap_bus.ir == spp_pkg::IR_PROGRAM) begin
            prog_bit_out <= tap_bus.tdi;
         end
      end
   end

   // serial out changes on the falling test clock, as the tester expects
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tdo_bit <= 1'b0;
         tdo_drive <= 1'b0;
      end else if (!scan_active) begin
         tdo_drive <= 1'b0;
      end else if (tck_fall) begin
         tdo_drive <= in_shift;
         if (in_shift_ir) begin
            tdo_bit <= tap_bus.ir_lsb;
         end else if (in_shift_dr) begin
            tdo_bit <= dr_shift[0];
         end
      end
   end

   // probe channels; fuse gates the enables even before the setup clears
   assign probe_a_field = cfg_field(probe_cfg, 1'b0);
   assign probe_b_field = cfg_field(probe_cfg, 1'b1);
   assign probe_a_en = probe_a_field[SEL_W] & ~probe_fuse_blown_in;
   assign probe_b_en = probe_b_field[SEL_W] & ~probe_fuse_blown_in;
   assign probe_a_sel = probe_a_field[SEL_W-1:0];
   assign probe_b_sel = probe_b_field[SEL_W-1:0];
   assign probe_a_val = pick_node(probe_node_in, probe_a_sel);
   assign probe_b_val = pick_node(probe_node_in, probe_b_sel);

   // registered pin drivers; one cycle of latency buys glitch-free pads
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shared_pin_out <= '0;
         shared_pin_oe_n_out <= '1;
      end else begin
         if (scan_active) begin
            // clock and data in are inputs to the scan logic
            shared_pin_out[spp_pkg::PIN_TCK] <= 1'b0;
            shared_pin_oe_n_out[spp_pkg::PIN_TCK] <= 1'b1;
            shared_pin_out[spp_pkg::PIN_TDI] <= 1'b0;
            shared_pin_oe_n_out[spp_pkg::PIN_TDI] <= 1'b1;
            shared_pin_out[spp_pkg::PIN_TDO] <= tdo_bit;
            shared_pin_oe_n_out[spp_pkg::PIN_TDO] <= ~tdo_drive;
         end else begin
            shared_pin_out[spp_pkg::PIN_TDO:spp_pkg::PIN_TCK] <=
               user_pin_data_in[spp_pkg::PIN_TDO:spp_pkg::PIN_TCK];
            shared_pin_oe_n_out[spp_pkg::PIN_TDO:spp_pkg::PIN_TCK] <=
               user_pin_oe_n_in[spp_pkg::PIN_TDO:spp_pkg::PIN_TCK];
         end
         // probe pins fall back to the user when not probing
         shared_pin_out[spp_pkg::PIN_PROBE_A] <= probe_a_en ? probe_a_val
                                                 : user_pin_data_in[spp_pkg::PIN_PROBE_A];
         shared_pin_oe_n_out[spp_pkg::PIN_PROBE_A] <= probe_a_en ? 1'b0
                                                     : user_pin_oe_n_in[spp_pkg::PIN_PROBE_A];
         shared_pin_out[spp_pkg::PIN_PROBE_B] <= probe_b_en ? probe_b_val
                                                 : user_pin_data_in[spp_pkg::PIN_PROBE_B];
         shared_pin_oe_n_out[spp_pkg::PIN_PROBE_B] <= probe_b_en ? 1'b0
                                                     : user_pin_oe_n_in[spp_pkg::PIN_PROBE_B];
      end
   end

   // user sees the synchronised pad levels whatever the role
   assign user_pin_read_out = sync_b[spp_pkg::NUM_PINS-1:0];
   assign scan_active_out = scan_active;

endmodule

// >>> tb/spp_scan_pin_sva.sv
// Purpose: port checks for scan pin sharing and the probe pins
// Assumes: one clock domain; pads sampled by clk_sys_in
// Notes: bound onto the top module at the foot of this file
`timescale 1ns/1ps
module spp_scan_pin_sva #(
   parameter int NUM_NODES = 16
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic dedicated_mode_in,
   input wire logic probe_fuse_blown_in,
   input wire logic tms_in,
   input wire logic [spp_pkg::NUM_PINS-1:0] shared_pin_out,
   input wire logic [spp_pkg::NUM_PINS-1:0] shared_pin_oe_n_out,
   input wire logic [spp_pkg::NUM_PINS-1:0] user_pin_data_in,
   input wire logic [spp_pkg::NUM_PINS-1:0] user_pin_oe_n_in,
   input wire logic scan_active_out,
   input wire logic prog_bit_valid_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   // steady role for two samples, so registered pins have caught up
   sequence s_scan_steady;
      scan_active_out [*2];
   endsequence
   sequence s_user_steady;
      !scan_active_out [*2];
   endsequence
   // mode select low long enough to pass the sync flops
   sequence s_tms_low;
      !tms_in [*3];
   endsequence
   a_scan_enter: assert property (s_tms_low |=> scan_active_out)
      else $error("scan role not taken after mode select low");
   a_scan_hold: assert property ($fell(scan_active_out) |-> $past(tms_in, 3) && $past(tms_in, 20))
      else $error("scan role left without mode select high");
   a_scan_pins_in: assert property (s_scan_steady |-> &shared_pin_oe_n_out[1:0])
      else $error("clock or data in pad driven in scan role");
   a_user_follow: assert property (s_user_steady and $past(arst_n_in) |->
      shared_pin_out[2:0] == $past(user_pin_data_in[2:0]) &&
      shared_pin_oe_n_out[2:0] == $past(user_pin_oe_n_in[2:0]))
      else $error("scan pads not following user logic");
   a_prog_single: assert property (prog_bit_valid_out |=> !prog_bit_valid_out)
      else $error("programming strobe longer than one cycle");
   a_prog_in_scan: assert property (prog_bit_valid_out |-> scan_active_out)
      else $error("programming strobe outside scan role");
   a_fuse_user: assert property ($past(probe_fuse_blown_in) && $past(arst_n_in) |->
      shared_pin_out[4:3] == $past(user_pin_data_in[4:3]) &&
      shared_pin_oe_n_out[4:3] == $past(user_pin_oe_n_in[4:3]))
      else $error("probe pads not user driven after fuse");
   a_ded_scan: assert property (dedicated_mode_in && $past(arst_n_in) |-> scan_active_out)
      else $error("dedicated mode left scan role");
endmodule

bind spp_scan_pin_top spp_scan_pin_sva #(.NUM_NODES(NUM_NODES)) i_spp_scan_pin_sva (
   .clk_sys_in, .arst_n_in, .dedicated_mode_in, .probe_fuse_blown_in, .tms_in, .shared_pin_out,
   .shared_pin_oe_n_out, .user_pin_data_in, .user_pin_oe_n_in, .scan_active_out, .prog_bit_valid_out);

// >>> tb/spp_tester.sv
// Purpose: behavioural boundary scan tester on the shared scan pads
// Assumes: test clock period 800 ns, phase unrelated to the system clock
// Notes: test clock stands low between frames
`timescale 1ns/1ps
module spp_tester (
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   input wire logic tdo_in
);
   // idle: mode select high keeps the pads in user role
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end
   // one cycle; data moves mid low phase, clear of both edges
   task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
      #230;
      tms_out = tms_v;
      tdi_out = tdi_v;
      #200;
      tck_out = 1'b1;
      #370;
      tdo_v = tdo_in; // taken before the fall that may move it
      tck_out = 1'b0;
   endtask
   // standard state walk, lsb first; data in floats inverted after the frame
   task automatic walk(input logic [15:0] tms_v, input logic [15:0] tdi_v, input int n,
                       output logic [15:0] tdo_v);
      tdo_v = '0;
      for (int i = 0; i < n; i++) begin
         step(tms_v[i], tdi_v[i], tdo_v[i]);
      end
      tdi_out = ~tdi_out;
   endtask
   // mode select low well ahead of the first clock
   task automatic enter();
      tms_out = 1'b0;
      #500;
   endtask
   // cycles with mode select high that walk the controller home
   task automatic leave(input int n);
      logic d;
      repeat (n) step(1'b1, tdi_out, d);
   endtask
endmodule

// >>> tb/spp_scan_pin_top_tb.sv
// Purpose: self-checking bench for scan pin sharing and probe pins
// Assumes: 10 MHz system clock, tester model on the scan pads
// Notes: pad levels resolved from the top's output enables; tester and external drivers always drive
`timescale 1ns/1ps
module spp_scan_pin_top_tb;
   logic clk_sys_in, arst_n_in, ded, fuse, tck, tms, tdi, scan, pbit, pvalid;
   logic [4:0] ext, pad, pin_out, pin_oe_n, udata, uoe_n, uread;
   logic [15:0] node, tdo_seen, prog_seen;
   int prog_cnt, failures, total_checks;
   // a released pad shows whoever else drives it
   assign pad = (pin_oe_n & {ext[4:2], tdi, tck}) | (~pin_oe_n & pin_out);
   spp_scan_pin_top #(.NUM_NODES(16)) i_spp_scan_pin_top (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .dedicated_mode_in(ded),
      .probe_fuse_blown_in(fuse), .tms_in(tms), .shared_pin_in(pad), .shared_pin_out(pin_out),
      .shared_pin_oe_n_out(pin_oe_n), .user_pin_data_in(udata), .user_pin_oe_n_in(uoe_n),
      .user_pin_read_out(uread), .probe_node_in(node), .scan_active_out(scan),
      .prog_bit_out(pbit), .prog_bit_valid_out(pvalid));
   spp_tester i_spp_tester (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(pad[2]));
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   // programming bits as handed out, first bit ends lowest
   always @(posedge clk_sys_in) begin
      if (pvalid === 1'b1) begin
         prog_seen <= {pbit, prog_seen[15:1]};
         prog_cnt <= prog_cnt + 1;
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   // mode is static, so it only moves under reset
   task automatic do_reset(input logic ded_v);
      arst_n_in = 1'b0;
      ded = ded_v;
      cyc(10);
      chk(pin_oe_n, 5'h1F);
      chk(scan, 1'b0);
      arst_n_in = 1'b1;
      cyc(2);
      chk(scan, ded_v);
   endtask
   task automatic load_ir(input logic [3:0] code);
      i_spp_tester.walk(16'h0306, {7'h00, code, 5'h00}, 11, tdo_seen);
   endtask
   // from idle: n data bits, then extra cycles past the exit state
   task automatic load_dr(input logic [15:0] word, input int n, input int extra);
      logic [15:0] t;
      t = 16'h0001 | (16'h0003 << (n + 2));
      i_spp_tester.walk(t, word << 3, n + 3 + extra, tdo_seen);
   endtask
   // both probes on, a on node 5, b on node 9
   task automatic load_probe();
      i_spp_tester.enter();
      load_ir(spp_pkg::IR_PROBE_SEL);
      load_dr(16'h0335, 10, 2);
      i_spp_tester.leave(5);
      cyc(8);
   endtask
   task automatic test_user();
      i_spp_tester.leave(5);
      cyc(4);
      chk(scan, 1'b0);
      chk(pin_out, 5'h0A);
      chk(pin_oe_n, 5'h10);
      chk(uread, 5'h1A);
      // user moves its drive; pads must track it in user role
      udata = 5'h06;
      uoe_n = 5'h1C;
      cyc(4);
      chk(pin_out, 5'h06);
      chk(pin_oe_n, 5'h1C);
      chk(uread, 5'h16);
      $display("test user done");
   endtask
   task automatic test_prog();
      i_spp_tester.enter();
      chk(scan, 1'b1);
      cyc(2);
      chk(pin_oe_n[1:0], 2'b11);
      load_ir(spp_pkg::IR_PROGRAM);
      chk(tdo_seen[8:5], spp_pkg::IR_CAPTURE_VAL);
      prog_cnt = 0;
      load_dr(16'h000A, 4, 0);
      cyc(3);
      chk(16'(prog_cnt), 16'd4);
      chk(prog_seen[15:12], 4'hA);
      i_spp_tester.leave(3);
      cyc(8);
      chk(scan, 1'b1);
      i_spp_tester.leave(1);
      cyc(8);
      chk(scan, 1'b0);
      chk(pin_out[2:0], udata[2:0]);
      chk(pin_oe_n[2:0], uoe_n[2:0]);
      $display("test prog done");
   endtask
   task automatic test_probe();
      load_probe();
      node = 16'h0020;
      cyc(2);
      chk(pin_oe_n[4:3], 2'b00);
      chk(pin_out[4:3], 2'b01);
      node = 16'h0200;
      cyc(2);
      chk(pin_out[4:3], 2'b10);
      fuse = 1'b1;
      cyc(2);
      chk(pin_out[4:3], udata[4:3]);
      chk(pin_oe_n[4:3], uoe_n[4:3]);
      load_probe();
      chk(pin_oe_n[4:3], uoe_n[4:3]);
      $display("test probe done");
   endtask
   task automatic test_ded();
      do_reset(1'b1);
      chk(scan, 1'b1);
      load_ir(spp_pkg::IR_BYPASS);
      chk(tdo_seen[8:5], spp_pkg::IR_CAPTURE_VAL);
      i_spp_tester.leave(5);
      cyc(8);
      chk(scan, 1'b1);
      chk(pin_oe_n[1:0], 2'b11);
      $display("test dedicated done");
   endtask
   initial begin
      arst_n_in = 1'b0;
      ded = 1'b0;
      fuse = 1'b0;
      ext = 5'h14;
      udata = 5'h0A;
      uoe_n = 5'h10;
      node = '0;
      failures = 0;
      total_checks = 0;
      prog_cnt = 0;
      prog_seen = '0;
      do_reset(1'b0);
      test_user();
      test_prog();
      test_probe();
      test_ded();
      finish_test();
   end
   // the run needs about 94 us; far beyond that something hangs
   initial begin
      #1000000;
      failures++;
      finish_test();
   end
endmodule
